// ==== pkg/rtcs_map.vh ====
`ifndef RTCS_MAP_VH
`define RTCS_MAP_VH

// Register offsets
`define RTCS_ADDR_W           8
`define RTCS_OFS_EVT          8'h01
`define RTCS_OFS_PWR          8'h02
`define RTCS_OFS_CLK          8'h0F

// event_flags_and_irq_enables fields
`define RTCS_EVT_TICK         7
`define RTCS_EVT_WDOG         6
`define RTCS_EVT_TAMP         5
`define RTCS_EVT_ALRM         4
`define RTCS_EVT_CDWN         3
`define RTCS_EVT_TIMESTAMP_IRQ_EN         2
`define RTCS_EVT_AIE          1
`define RTCS_EVT_CDIE         0

// power_and_battery_control fields
`define RTCS_PWR_MODE_HI      7
`define RTCS_PWR_MODE_LO      5
`define RTCS_PWR_CAPEN        4
`define RTCS_PWR_SWF          3
`define RTCS_PWR_BLF          2
`define RTCS_PWR_SWIE         1
`define RTCS_PWR_BATTERY_LOW_IRQ_EN         0
`define RTCS_PWR_RESET        8'h00

// clock_output_control fields
`define RTCS_CLK_RATE_HI      7
`define RTCS_CLK_RATE_LO      6
`define RTCS_CLK_REFRESH      5
`define RTCS_CLK_FSEL_HI      2
`define RTCS_CLK_FSEL_LO      0
`define RTCS_RATE_RESET       2'h0
`define RTCS_FSEL_RESET       3'h0
`define RTCS_FSEL_1HZ         3'h6
`define RTCS_FSEL_OFF         3'h7

// Timing
`define RTCS_CLK_HZ           25000000
`define RTCS_SQW_BASE_HZ      65536
`define RTCS_MEAS_4MIN_S      240
`define RTCS_MEAS_2MIN_S      120
`define RTCS_MEAS_1MIN_S      60
`define RTCS_MEAS_30S_S       30
`define RTCS_REFRESH_MS       100
`define RTCS_REFRESH_CYC      ((`RTCS_CLK_HZ / 1000) * `RTCS_REFRESH_MS)

`endif

// ==== rtl/rtcs_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_map.vh"

module rtcs_regs #(
  parameter integer CLK_HZ      = `RTCS_CLK_HZ,
  parameter integer REFRESH_CYC = `RTCS_REFRESH_CYC,
  parameter integer DUTY_W      = 8
) (
  input  wire                      ref_clk,
  input  wire                      reset_n,
  input  wire [`RTCS_ADDR_W-1:0]   reg_addr,
  input  wire [7:0]                reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [7:0]                reg_rdata_q,
  input  wire                      tick_event,
  input  wire                      tick_irq_en,
  input  wire                      watchdog_event,
  input  wire                      watchdog_irq_en,
  input  wire                      tamper_event_pin_n,
  input  wire                      alarm_match,
  input  wire                      countdown_expired,
  input  wire                      switchover_event,
  input  wire                      battery_low,
  input  wire [DUTY_W-1:0]         comp_duty,
  output reg                       irq_q,
  output reg                       switchover_capture_q,
  output reg  [2:0]                power_mgmt_mode_q,
  output reg                       temp_meas_q,
  output reg                       cap_select_q,
  output reg                       calib_refresh_busy_q,
  output reg                       square_wave_pin_o_q,
  output reg                       square_wave_pin_oe_q
);

  localparam [31:0] CLK_HZ_W     = CLK_HZ;
  localparam [31:0] SEC_LAST     = CLK_HZ_W - 32'h00000001;
  localparam [31:0] REF_LAST     = REFRESH_CYC - 1;
  localparam [31:0] SQW_STEP     = `RTCS_SQW_BASE_HZ;
  localparam [31:0] MEAS4M_LAST  = `RTCS_MEAS_4MIN_S - 1;
  localparam [31:0] MEAS2M_LAST  = `RTCS_MEAS_2MIN_S - 1;
  localparam [31:0] MEAS1M_LAST  = `RTCS_MEAS_1MIN_S - 1;
  localparam [31:0] MEAS30S_LAST = `RTCS_MEAS_30S_S - 1;

  // Address decode shared by the write strobes and the read mux
  function addr_hit;
    input [`RTCS_ADDR_W-1:0] addr;
    input [`RTCS_ADDR_W-1:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  wire wr_evt = reg_wr && addr_hit(reg_addr, `RTCS_OFS_EVT);
  wire wr_pwr = reg_wr && addr_hit(reg_addr, `RTCS_OFS_PWR);
  wire wr_clk = reg_wr && addr_hit(reg_addr, `RTCS_OFS_CLK);

  // Sticky flag update: a new event wins over a write-zero clear
  function sticky;
    input cur;
    input set;
    input wr;
    input wbit;
    begin
      sticky = set | (cur & ~(wr & ~wbit));
    end
  endfunction

  reg        tick_flag_q;
  reg        watchdog_flag_q;
  reg        tamper_flag_q;
  reg        alarm_flag_q;
  reg        countdown_flag_q;
  reg        timestamp_irq_en_q;
  reg        alarm_irq_en_q;
  reg        countdown_irq_en_q;
  reg        switchover_capture_en_q;
  reg        switchover_flag_q;
  reg        battery_low_flag_q;
  reg        switchover_irq_en_q;
  reg        battery_low_irq_en_q;
  reg [1:0]  temp_meas_rate_q;
  reg        calib_refresh_q;
  reg [2:0]  out_freq_sel_q;
  reg        tamper_pin_prev_q;

  wire tamper_fall = tamper_pin_prev_q & ~tamper_event_pin_n;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_flag_q             <= 1'b0;
      watchdog_flag_q         <= 1'b0;
      tamper_flag_q           <= 1'b0;
      alarm_flag_q            <= 1'b0;
      countdown_flag_q        <= 1'b0;
      timestamp_irq_en_q      <= 1'b0;
      alarm_irq_en_q          <= 1'b0;
      countdown_irq_en_q      <= 1'b0;
      power_mgmt_mode_q       <= 3'h0;
      switchover_capture_en_q <= 1'b0;
      switchover_flag_q       <= 1'b0;
      battery_low_flag_q      <= 1'b0;
      switchover_irq_en_q     <= 1'b0;
      battery_low_irq_en_q    <= 1'b0;
      temp_meas_rate_q        <= `RTCS_RATE_RESET;
      out_freq_sel_q          <= `RTCS_FSEL_RESET;
      tamper_pin_prev_q       <= 1'b1;
    end else begin
      tamper_pin_prev_q <= tamper_event_pin_n;
      tick_flag_q <= sticky(tick_flag_q, tick_event, wr_evt,
                            reg_wdata[`RTCS_EVT_TICK]);
      watchdog_flag_q <= watchdog_flag_q | watchdog_event;
      tamper_flag_q <= sticky(tamper_flag_q, tamper_fall, wr_evt,
                              reg_wdata[`RTCS_EVT_TAMP]);
      alarm_flag_q <= sticky(alarm_flag_q, alarm_match, wr_evt,
                             reg_wdata[`RTCS_EVT_ALRM]);
      countdown_flag_q <= sticky(countdown_flag_q, countdown_expired, wr_evt,
                                 reg_wdata[`RTCS_EVT_CDWN]);
      switchover_flag_q <= sticky(switchover_flag_q, switchover_event, wr_pwr,
                                  reg_wdata[`RTCS_PWR_SWF]);
      battery_low_flag_q <= battery_low;
      if (wr_evt) begin
        timestamp_irq_en_q <= reg_wdata[`RTCS_EVT_TIMESTAMP_IRQ_EN];
        alarm_irq_en_q     <= reg_wdata[`RTCS_EVT_AIE];
        countdown_irq_en_q <= reg_wdata[`RTCS_EVT_CDIE];
      end
      if (wr_pwr) begin
        power_mgmt_mode_q       <= reg_wdata[`RTCS_PWR_MODE_HI:`RTCS_PWR_MODE_LO];
        switchover_capture_en_q <= reg_wdata[`RTCS_PWR_CAPEN];
        switchover_irq_en_q     <= reg_wdata[`RTCS_PWR_SWIE];
        battery_low_irq_en_q    <= reg_wdata[`RTCS_PWR_BATTERY_LOW_IRQ_EN];
      end
      if (wr_clk) begin
        temp_meas_rate_q <= reg_wdata[`RTCS_CLK_RATE_HI:`RTCS_CLK_RATE_LO];
        out_freq_sel_q   <= reg_wdata[`RTCS_CLK_FSEL_HI:`RTCS_CLK_FSEL_LO];
      end
    end
  end

  // Refresh bit survives resets, so it has no reset branch
  always @(posedge ref_clk) begin
    if (wr_clk) begin
      calib_refresh_q <= reg_wdata[`RTCS_CLK_REFRESH];
    end
  end

  // Read port: data stand only in the cycle after the strobe
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (addr_hit(reg_addr, `RTCS_OFS_EVT)) begin
      rd_mux = {tick_flag_q, watchdog_flag_q, tamper_flag_q, alarm_flag_q,
                countdown_flag_q, timestamp_irq_en_q, alarm_irq_en_q,
                countdown_irq_en_q};
    end else if (addr_hit(reg_addr, `RTCS_OFS_PWR)) begin
      rd_mux = {power_mgmt_mode_q, switchover_capture_en_q, switchover_flag_q,
                battery_low_flag_q, switchover_irq_en_q, battery_low_irq_en_q};
    end else if (addr_hit(reg_addr, `RTCS_OFS_CLK)) begin
      rd_mux = {temp_meas_rate_q, calib_refresh_q, 2'b00, out_freq_sel_q};
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Interrupt and capture outputs
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q                <= 1'b0;
      switchover_capture_q <= 1'b0;
    end else begin
      irq_q <= (tick_flag_q & tick_irq_en)
             | (watchdog_flag_q & watchdog_irq_en)
             | (tamper_flag_q & timestamp_irq_en_q)
             | (alarm_flag_q & alarm_irq_en_q)
             | (countdown_flag_q & countdown_irq_en_q)
             | (switchover_flag_q & switchover_irq_en_q)
             | (battery_low_flag_q & battery_low_irq_en_q);
      switchover_capture_q <= switchover_event & switchover_capture_en_q;
    end
  end

  // Calibration refresh: a write that takes the bit from zero to one
  reg [31:0] ref_cnt_q;
  wire refresh_go = wr_clk && reg_wdata[`RTCS_CLK_REFRESH] && (calib_refresh_q == 1'b0);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      calib_refresh_busy_q <= 1'b0;
      ref_cnt_q            <= 32'h00000000;
    end else if (refresh_go && !calib_refresh_busy_q) begin
      calib_refresh_busy_q <= 1'b1;
      ref_cnt_q            <= 32'h00000000;
    end else if (calib_refresh_busy_q) begin
      if (ref_cnt_q >= REF_LAST) begin
        calib_refresh_busy_q <= 1'b0;
      end else begin
        ref_cnt_q <= ref_cnt_q + 32'h00000001;
      end
    end
  end

  // One-second enable and temperature measurement scheduler
  reg [31:0] sec_div_q;
  reg        sec_en_q;
  reg [7:0]  meas_sec_q;
  reg        meas_first_q;
  reg [7:0]  meas_last;
  always @* begin
    case (temp_meas_rate_q)
      2'h0:    meas_last = MEAS4M_LAST[7:0];
      2'h1:    meas_last = MEAS2M_LAST[7:0];
      2'h2:    meas_last = MEAS1M_LAST[7:0];
      default: meas_last = MEAS30S_LAST[7:0];
    endcase
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_div_q    <= 32'h00000000;
      sec_en_q     <= 1'b0;
      meas_sec_q   <= 8'h00;
      meas_first_q <= 1'b1;
      temp_meas_q  <= 1'b0;
    end else begin
      sec_en_q <= (sec_div_q >= SEC_LAST);
      sec_div_q <= (sec_div_q >= SEC_LAST) ? 32'h00000000 : sec_div_q + 32'h00000001;
      temp_meas_q <= 1'b0;
      if (meas_first_q) begin
        meas_first_q <= 1'b0;
        temp_meas_q  <= 1'b1;
      end else if (sec_en_q) begin
        if (meas_sec_q >= meas_last) begin
          meas_sec_q  <= 8'h00;
          temp_meas_q <= 1'b1;
        end else begin
          meas_sec_q <= meas_sec_q + 8'h01;
        end
      end
    end
  end

  // Load capacitor modulation: duty follows the compensation result
  reg [DUTY_W-1:0] pwm_cnt_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_cnt_q    <= {DUTY_W{1'b0}};
      cap_select_q <= 1'b0;
    end else begin
      pwm_cnt_q    <= pwm_cnt_q + {{(DUTY_W-1){1'b0}}, 1'b1};
      cap_select_q <= (pwm_cnt_q < comp_duty);
    end
  end

  // Square wave: exact-average 65536 Hz steps drive a 16-bit counter
  reg [31:0] sqw_acc_q;
  reg [15:0] sqw_cnt_q;
  reg        sqw_level;
  wire [31:0] sqw_sum  = sqw_acc_q + SQW_STEP;
  wire        sqw_step = (sqw_sum >= CLK_HZ_W);
  always @* begin
    case (out_freq_sel_q)
      3'h0:    sqw_level = sqw_cnt_q[0];
      3'h1:    sqw_level = sqw_cnt_q[1];
      3'h2:    sqw_level = sqw_cnt_q[2];
      3'h3:    sqw_level = sqw_cnt_q[3];
      3'h4:    sqw_level = sqw_cnt_q[4];
      3'h5:    sqw_level = sqw_cnt_q[5];
      3'h6:    sqw_level = sqw_cnt_q[15];
      default: sqw_level = 1'b1;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sqw_acc_q            <= 32'h00000000;
      sqw_cnt_q            <= 16'h0000;
      square_wave_pin_o_q  <= 1'b0;
      square_wave_pin_oe_q <= 1'b0;
    end else begin
      sqw_acc_q <= sqw_step ? (sqw_sum - CLK_HZ_W) : sqw_sum;
      if (sqw_step) begin
        sqw_cnt_q <= sqw_cnt_q + 16'h0001;
      end
      square_wave_pin_o_q <= 1'b0;
      // Open drain: pull low on the low half, release when disabled
      square_wave_pin_oe_q <= (out_freq_sel_q != `RTCS_FSEL_OFF) & ~sqw_level;
    end
  end

endmodule
`default_nettype wire

// ==== test/rtcs_regs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtcs_regs_monitor #(
  parameter integer REFRESH_CYC = 2500000
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       watchdog_event,
  input wire logic       watchdog_irq_en,
  input wire logic       battery_low,
  input wire logic       switchover_event,
  input wire logic       irq_q,
  input wire logic       switchover_capture_q,
  input wire logic       temp_meas_q,
  input wire logic       calib_refresh_busy_q,
  input wire logic       square_wave_pin_oe_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] busy_cnt_q;
  logic [7:0] busy_cnt_d;
  assign busy_cnt_d = calib_refresh_busy_q ? busy_cnt_q + 8'h01 : 8'h00;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= 8'h00;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
    else $error("read data not zero outside read cycle");
  a_unmapped_reads_zero: assert property (reg_rd && !(reg_addr inside {8'h01, 8'h02, 8'h0F})
    |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_unused_bits_zero: assert property (reg_rd && reg_addr == 8'h0F |=> reg_rdata_q[4:3] == 2'h0)
    else $error("unused clock control bits not zero");
  a_wdog_flag_sticks: assert property (watchdog_event ##1 (reg_rd && reg_addr == 8'h01)
    |=> reg_rdata_q[6])
    else $error("watchdog flag not seen");
  a_wdog_irq_raise: assert property (watchdog_event && watchdog_irq_en ##1 watchdog_irq_en
    |=> irq_q)
    else $error("enabled watchdog flag gave no interrupt");
  a_batt_low_follow: assert property (reg_rd && reg_addr == 8'h02
    |=> reg_rdata_q[2] == $past(battery_low, 2))
    else $error("battery low flag does not follow detector");
  a_capture_cause: assert property (switchover_capture_q |-> $past(switchover_event))
    else $error("capture without switchover");
  a_meas_after_reset: assert property ($rose(reset_n) |=> temp_meas_q)
    else $error("no measurement after reset");
  a_refresh_length: assert property ($fell(calib_refresh_busy_q)
    |-> busy_cnt_q == REFRESH_CYC[7:0])
    else $error("refresh busy length wrong");
  a_output_off: assert property (reg_wr && reg_addr == 8'h0F && reg_wdata[2:0] == 3'h7
    |-> ##2 !square_wave_pin_oe_q [*3])
    else $error("square wave pin driven while off");
endmodule
bind rtcs_regs rtcs_regs_monitor #(.REFRESH_CYC(REFRESH_CYC)) mon (.ref_clk, .reset_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .watchdog_event, .watchdog_irq_en,
  .battery_low, .switchover_event, .irq_q, .switchover_capture_q, .temp_meas_q,
  .calib_refresh_busy_q, .square_wave_pin_oe_q);
`default_nettype wire

// ==== test/rtcs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtcs_host (
  input wire logic       ref_clk,
  input wire logic [7:0] reg_rdata_q,
  output var logic [7:0] reg_addr = 8'h00,
  output var logic [7:0] reg_wdata = 8'h00,
  output var logic       reg_wr = 1'b0,
  output var logic       reg_rd = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

// ==== test/rtc_control_status_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_control_status_regs_tb;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [5:0] ev = 6'h00;
  logic       batt = 1'b0;
  logic       tick_en = 1'b0;
  logic       wdog_en = 1'b0;
  logic       caught = 1'b0;
  logic [7:0] rv;
  logic [7:0] duty = 8'h00;
  int         ones = 0;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata_q;
  wire  [2:0] pm;
  wire        reg_wr, reg_rd, irq_q, cap, busy, oe, sq_o, capsel;
  int         fails = 0;
  int         comparisons = 0;
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (cap) caught <= 1'b1;
  rtcs_host host (.ref_clk, .reg_rdata_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  rtcs_regs #(.CLK_HZ(1000), .REFRESH_CYC(20)) dut (.ref_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .tick_event(ev[0]), .tick_irq_en(tick_en),
    .watchdog_event(ev[1]), .watchdog_irq_en(wdog_en), .tamper_event_pin_n(~ev[2]),
    .alarm_match(ev[3]), .countdown_expired(ev[4]), .switchover_event(ev[5]),
    .battery_low(batt), .comp_duty(duty), .irq_q, .switchover_capture_q(cap),
    .power_mgmt_mode_q(pm), .temp_meas_q(), .cap_select_q(capsel),
    .calib_refresh_busy_q(busy), .square_wave_pin_o_q(sq_o), .square_wave_pin_oe_q(oe));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string n);
    host.rd(a, rv);
    chk(n, rv & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk) ev[i] <= 1'b1;
    @(posedge ref_clk) ev[i] <= 1'b0;
    cyc(3);
  endtask
  task automatic irq_is(input string n, input logic e);
    cyc(3);
    chk(n, {7'h00, irq_q}, {7'h00, e});
  endtask
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    cyc(8);
    reset_n <= 1'b1;
    cyc(2);
    rchk(8'h01, 8'hFF, 8'h00, "evt_rst");
    rchk(8'h02, 8'hFF, 8'h00, "pwr_rst");
    rchk(8'h0F, 8'hDF, 8'h00, "clk_rst");
    host.wr(8'h05, 8'hFF);
    rchk(8'h05, 8'hFF, 8'h00, "unmapped");
    host.wr(8'h02, 8'hFF);
    rchk(8'h02, 8'hFF, 8'hF3, "pwr_rw");
    chk("mode", {5'h00, pm}, 8'h07);
    pulse(5);
    chk("capture", {7'h00, caught}, 8'h01);
    rchk(8'h02, 8'hFF, 8'hFB, "swo_set");
    irq_is("swo_irq", 1'b1);
    host.wr(8'h02, 8'hE0);
    rchk(8'h02, 8'hFF, 8'hE0, "swo_clr");
    irq_is("swo_off", 1'b0);
    caught <= 1'b0;
    pulse(5);
    chk("no_capture", {7'h00, caught}, 8'h00);
    irq_is("swo_mask", 1'b0);
    batt <= 1'b1;
    cyc(3);
    host.wr(8'h02, 8'h00);
    rchk(8'h02, 8'hFF, 8'h04, "blf_keep");
    irq_is("blf_mask", 1'b0);
    host.wr(8'h02, 8'h01);
    irq_is("blf_irq", 1'b1);
    batt <= 1'b0;
    irq_is("blf_gone", 1'b0);
    host.wr(8'h02, 8'h00);
    for (int i = 0; i < 5; i++) pulse(i);
    rchk(8'h01, 8'hFF, 8'hF8, "flags");
    host.wr(8'h01, 8'h00);
    rchk(8'h01, 8'hFF, 8'h40, "flags_clr");
    for (int i = 0; i < 3; i++) begin
      pulse(i + 2);
      irq_is("gate_off", 1'b0);
      host.wr(8'h01, (8'h20 >> i) | (8'h04 >> i));
      irq_is("gate_on", 1'b1);
      host.wr(8'h01, 8'h04 >> i);
      irq_is("gate_clr", 1'b0);
    end
    tick_en <= 1'b1;
    pulse(0);
    irq_is("tick_irq", 1'b1);
    host.wr(8'h01, 8'h00);
    irq_is("tick_clr", 1'b0);
    duty <= 8'h80;
    cyc(3);
    repeat (256) @(posedge ref_clk) ones += capsel;
    chk("duty", ones[7:0], 8'h80);
    host.wr(8'h0F, 8'h00);
    host.wr(8'h0F, 8'h20);
    cyc(2);
    chk("busy", {7'h00, busy}, 8'h01);
    cyc(21);
    chk("idle", {7'h00, busy}, 8'h00);
    host.wr(8'h0F, 8'hFF);
    rchk(8'h0F, 8'hFF, 8'hE7, "clk_rw");
    chk("pin_off", {7'h00, oe}, 8'h00);
    chk("pin_data", {7'h00, sq_o}, 8'h00);
    host.wr(8'h0F, 8'h21);
    wdog_en <= 1'b1;
    pulse(1);
    chk("wdog_irq", {7'h00, irq_q}, 8'h01);
    ev[1] <= 1'b1;
    rchk(8'h01, 8'h40, 8'h40, "wdog_read");
    @(posedge ref_clk) ev[1] <= 1'b0;
    wdog_en <= 1'b0;
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(2);
    rchk(8'h0F, 8'hFF, 8'h20, "clk_keep");
    rchk(8'h01, 8'hFF, 8'h00, "evt_again");
    wrap_up();
  end
endmodule
`default_nettype wire
